/* uart_pkg.sv */
// package: register map, field positions, reset values and types of the uart
package uart_pkg;
    // register word offsets on the byte-wide register port
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IEN = 3'h1;
    localparam logic [2:0] OFS_IID = 3'h2;
    localparam logic [2:0] OFS_LFC = 3'h3;
    localparam logic [2:0] OFS_MLC = 3'h4;
    localparam logic [2:0] OFS_LCS = 3'h5;
    // line format control fields
    localparam int LFC_STB = 2;
    localparam int LFC_PEN = 3;
    localparam int LFC_EPS = 4;
    localparam int LFC_BRK = 6;
    localparam int LFC_DAS = 7;
    // interrupt enable fields
    localparam int IEN_RDA = 0;
    localparam int IEN_THRE = 1;
    localparam int IEN_RLS = 2;
    // buffer control fields
    localparam int BUF_EN = 0;
    localparam int BUF_RXRST = 1;
    localparam int BUF_TXRST = 2;
    localparam int BUF_DMA = 3;
    localparam int BUF_TRIG_LO = 6;
    // modem line control fields
    localparam int MLC_DTR = 0;
    localparam int MLC_RTS = 1;
    localparam int MLC_LOOP = 4;
    // interrupt identity codes, bit 0 low means pending
    localparam logic [3:0] IID_NONE = 4'h1;
    localparam logic [3:0] IID_RLS = 4'h6;
    localparam logic [3:0] IID_RDA = 4'h4;
    localparam logic [3:0] IID_THRE = 4'h2;
    // reset values
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0000;
    // baud generator: zero divisor stands for 32, sixteen ticks per bit
    localparam logic [15:0] DIV_ZERO_SUB = 16'h0020;
    localparam logic [5:0] TICKS_BIT = 6'h10;
    localparam logic [5:0] TICKS_ONE_HALF = 6'h18;
    localparam logic [5:0] TICKS_TWO = 6'h20;
    localparam logic [3:0] TICKS_MID = 4'h7;
    // register port request from the processor side
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    // serial engine states
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage : uart_pkg

/* uart_serial_controller.sv */
// uart channel: baud generator, buffers, serial engines, registers
//
// What this block does
// R01: baud tick runs at sixteen times baud
// R02: both engines use one sixteen-bit divisor
// R03: divisor one ticks every system clock
// R04: zero divisor acts as thirty-two
// R05: divisor writes change rate at once
// R06: transmit adds parity and stop bits
// R07: transmit sends bit zero first
// R08: receive data read-only, first bit lowest
// R09: access bit clear selects data and enables
// R10: access bit set selects divisor bytes
// R11: interrupt output is inverse identity bit zero
// R12: disabled sources never pend nor interrupt
// R13: software clears uart before interrupt controller
// R14: three priority levels reported in identity
// R15: identity read shows value frozen at start
// R16: events still recorded during identity read
// R17: write-only control drives sixteen-entry buffers
// R18: leaving buffered mode keeps buffer contents
// R19: dma mode flags transmit full and receive at trigger level
// R20: received byte and errors shown in status
// R21: line format shared by both engines
// R22: modem outputs reach pins on first channel
// R23: five to eight bits, parity, stop lengths
// R24: receiver samples mid-bit after falling edge
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module uart_serial_controller #(
    parameter int DEPTH = 16,          // buffer entries each way
    parameter bit HAS_MODEM = 1'b1     // first channel drives modem pins
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // register port
    input wire uart_pkg::reg_req_t req,
    output logic [7:0] rdata,
    // serial line
    input wire logic rxd,
    output logic txd,
    // modem control towards the programmable pin port
    output logic dtr_n,
    output logic rts_n,
    // interrupt and dma indications
    output logic irq,
    output logic tx_buf_full,
    output logic rx_buf_full
);
    import uart_pkg::*;

    localparam int PW = $clog2(DEPTH);

    // the whole state of the channel
    typedef struct packed {
        logic [7:0] ien;
        logic [7:0] lfc;
        logic [7:0] mlc;
        logic [15:0] div;
        logic fifo_en;
        logic dma_en;
        logic [1:0] trig;
        logic [15:0] bcnt;                  // baud divider count
        logic tick;                         // sixteen-times baud pulse
        logic [DEPTH-1:0][7:0] txm;
        logic [DEPTH-1:0][7:0] rxm;
        logic [PW-1:0] twp;
        logic [PW-1:0] trp;
        logic [PW-1:0] rwp;
        logic [PW-1:0] rrp;
        logic [PW:0] tcnt;
        logic [PW:0] rcnt;
        tx_state_t ts;
        logic [7:0] tsh;                    // transmit shifter
        logic [2:0] tbit;
        logic [5:0] tt;                     // ticks within a bit
        logic tpar;
        logic txd;
        rx_state_t rs;
        logic [7:0] rsh;                    // receive shifter
        logic [2:0] rbit;
        logic [3:0] rt;
        logic rpar;
        logic rxd_d;                        // line level at last tick
        logic oe;
        logic pe;
        logic fe;
        logic bi;
        logic thre_pend;                    // holding empty event
        logic [3:0] iid;                    // reported identity
        logic [7:0] rdata;
    } st_t;

    st_t s_reg;       // registered state
    st_t s_next;      // next state
    logic tx_push;    // byte accepted into transmit buffer
    logic rx_push;    // byte stored into receive buffer
    logic [15:0] div_eff;
    logic [2:0] nlast;
    logic [PW:0] lim;
    logic [PW:0] trig_lvl;
    logic [3:0] iid_live;
    logic line_in;

    // combinational next state
    always_comb begin
        logic tx_pop;
        logic rx_pop;
        logic [7:0] rword;
        logic [7:0] mask;
        tx_pop = 1'b0;
        rx_pop = 1'b0;
        rword = 8'h00;
        mask = 8'hff >> (3'h3 - s_reg.lfc[1:0]);
        s_next = s_reg;
        tx_push = 1'b0;
        rx_push = 1'b0;
        nlast = {1'b1, s_reg.lfc[1:0]};     // five bits gives index four
        // in unbuffered mode the buffers behave as one-byte holders
        lim = s_reg.fifo_en ? (PW+1)'(DEPTH) : (PW+1)'(1);
        case (s_reg.trig)
            2'h0: trig_lvl = (PW+1)'(1);
            2'h1: trig_lvl = (PW+1)'(4);
            2'h2: trig_lvl = (PW+1)'(8);
            default: trig_lvl = (PW+1)'(14);
        endcase
        if (!s_reg.fifo_en) begin
            trig_lvl = (PW+1)'(1);
        end
        // baud divider reads the divisor live, so writes act at once
        div_eff = (s_reg.div == 16'h0000) ? DIV_ZERO_SUB : s_reg.div; // see R04
        if (s_reg.bcnt >= div_eff - 16'h0001) begin // see R01 R02 R03 R05
            s_next.bcnt = 16'h0000;
            s_next.tick = 1'b1;
        end else begin
            s_next.bcnt = s_reg.bcnt + 16'h0001;
            s_next.tick = 1'b0;
        end
        // loopback feeds the transmitter back into the receiver
        line_in = s_reg.mlc[MLC_LOOP] ? s_reg.txd : rxd;
        // priority ladder over enabled sources only
        if (s_reg.ien[IEN_RLS] && (s_reg.oe | s_reg.pe | s_reg.fe | s_reg.bi)) begin
            iid_live = IID_RLS;             // see R14 R12
        end else if (s_reg.ien[IEN_RDA] && s_reg.rcnt >= trig_lvl) begin
            iid_live = IID_RDA;             // see R14 R20
        end else if (s_reg.ien[IEN_THRE] && s_reg.thre_pend) begin
            iid_live = IID_THRE;            // see R14
        end else begin
            iid_live = IID_NONE;
        end
        // identity holds its value during its own read access
        if (!(req.rd && req.addr == OFS_IID)) begin
            s_next.iid = iid_live;          // see R15 R16
        end

        // register reads: data stand in the following cycle
        s_next.rdata = 8'h00;
        if (req.rd) begin
            if (req.addr == OFS_DATA) begin
                if (s_reg.lfc[LFC_DAS]) begin
                    s_next.rdata = s_reg.div[7:0]; // see R10
                end else begin
                    s_next.rdata = s_reg.rxm[s_reg.rrp]; // see R08 R09
                    rx_pop = (s_reg.rcnt != '0);
                end
            end else if (req.addr == OFS_IEN) begin
                s_next.rdata = s_reg.lfc[LFC_DAS] ? s_reg.div[15:8] : s_reg.ien;
            end else if (req.addr == OFS_IID) begin
                s_next.rdata = {s_reg.fifo_en, s_reg.fifo_en, 2'h0, s_reg.iid};
                // reporting the empty holder acknowledges it
                if (s_reg.iid == IID_THRE) begin
                    s_next.thre_pend = 1'b0;
                end
            end else if (req.addr == OFS_LFC) begin
                s_next.rdata = s_reg.lfc;
            end else if (req.addr == OFS_MLC) begin
                s_next.rdata = s_reg.mlc;
            end else if (req.addr == OFS_LCS) begin
                s_next.rdata = {s_reg.fifo_en & (s_reg.pe | s_reg.fe | s_reg.bi),
                    (s_reg.tcnt == '0) && (s_reg.ts == TX_IDLE),
                    s_reg.tcnt == '0, s_reg.bi, s_reg.fe, s_reg.pe,
                    s_reg.oe, s_reg.rcnt != '0}; // see R20
                // error flags clear on read; new errors below win
                s_next.oe = 1'b0;
                s_next.pe = 1'b0;
                s_next.fe = 1'b0;
                s_next.bi = 1'b0;
            end
        end

        // register writes
        if (req.wr) begin
            if (req.addr == OFS_DATA) begin
                if (s_reg.lfc[LFC_DAS]) begin
                    s_next.div[7:0] = req.wdata; // see R10 R05
                end else if (s_reg.tcnt < lim) begin
                    tx_push = 1'b1;         // see R09; a full holder drops it
                    s_next.txm[s_reg.twp] = req.wdata;
                    s_next.twp = s_reg.twp + PW'(1);
                    s_next.thre_pend = 1'b0;
                end
            end else if (req.addr == OFS_IEN) begin
                if (s_reg.lfc[LFC_DAS]) begin
                    s_next.div[15:8] = req.wdata; // see R10 R05
                end else begin
                    s_next.ien = req.wdata;     // see R09
                end
            end else if (req.addr == OFS_IID) begin
                // buffer control shares the identity offset, write side
                s_next.fifo_en = req.wdata[BUF_EN]; // see R17 R18
                s_next.dma_en = req.wdata[BUF_DMA];
                s_next.trig = req.wdata[BUF_TRIG_LO +: 2];
            end else if (req.addr == OFS_LFC) begin
                s_next.lfc = req.wdata;         // see R21
            end else if (req.addr == OFS_MLC) begin
                s_next.mlc = req.wdata;
            end
        end

        // transmitter, one state step per baud tick
        if (s_reg.tick) begin
            s_next.tt = s_reg.tt + 6'h01;
            case (s_reg.ts)
                TX_IDLE: begin
                    s_next.tt = 6'h00;
                    if (s_reg.tcnt != '0) begin
                        tx_pop = 1'b1;
                        s_next.tsh = s_reg.txm[s_reg.trp] & mask;
                        s_next.tpar = ^(s_reg.txm[s_reg.trp] & mask);
                        s_next.txd = 1'b0;  // see R06
                        s_next.ts = TX_START;
                    end
                end
                TX_START: begin
                    if (s_reg.tt == TICKS_BIT - 6'h01) begin
                        s_next.tt = 6'h00;
                        s_next.tbit = 3'h0;
                        s_next.txd = s_reg.tsh[0]; // see R07
                        s_next.ts = TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (s_reg.tt == TICKS_BIT - 6'h01) begin
                        s_next.tt = 6'h00;
                        if (s_reg.tbit == nlast) begin // see R23
                            if (s_reg.lfc[LFC_PEN]) begin
                                // even parity keeps the count of ones even
                                s_next.txd = s_reg.lfc[LFC_EPS] ? s_reg.tpar
                                                                : ~s_reg.tpar;
                                s_next.ts = TX_PAR; // see R06
                            end else begin
                                s_next.txd = 1'b1;
                                s_next.ts = TX_STOP;
                            end
                        end else begin
                            s_next.tbit = s_reg.tbit + 3'h1;
                            s_next.tsh = s_reg.tsh >> 1;
                            s_next.txd = s_reg.tsh[1];
                        end
                    end
                end
                TX_PAR: begin
                    if (s_reg.tt == TICKS_BIT - 6'h01) begin
                        s_next.tt = 6'h00;
                        s_next.txd = 1'b1;
                        s_next.ts = TX_STOP;
                    end
                end
                TX_STOP: begin
                    // one, one and a half or two stop bits
                    if (!s_reg.lfc[LFC_STB] && s_reg.tt == TICKS_BIT - 6'h01
                        || s_reg.lfc[LFC_STB] && s_reg.lfc[1:0] == 2'h0
                           && s_reg.tt == TICKS_ONE_HALF - 6'h01
                        || s_reg.lfc[LFC_STB] && s_reg.lfc[1:0] != 2'h0
                           && s_reg.tt == TICKS_TWO - 6'h01) begin // see R23
                        s_next.tt = 6'h00;
                        s_next.ts = TX_IDLE;
                    end
                end
                default: s_next.ts = TX_IDLE;
            endcase
        end

        // receiver, samples taken on baud ticks near bit centre
        if (s_reg.tick) begin
            s_next.rxd_d = line_in;
            s_next.rt = s_reg.rt + 4'h1;
            case (s_reg.rs)
                RX_IDLE: begin
                    s_next.rt = 4'h0;
                    if (s_reg.rxd_d && !line_in) begin
                        s_next.rs = RX_START; // see R24
                    end
                end
                RX_START: begin
                    // a glitch that is gone by mid-bit is not a start
                    if (s_reg.rt == TICKS_MID) begin // see R24
                        s_next.rt = 4'h0;
                        s_next.rbit = 3'h0;
                        s_next.rpar = 1'b0;
                        s_next.rs = line_in ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (s_reg.rt == 4'hf) begin
                        s_next.rsh = {line_in, s_reg.rsh[7:1]}; // see R08
                        s_next.rpar = s_reg.rpar ^ line_in;
                        s_next.rbit = s_reg.rbit + 3'h1;
                        if (s_reg.rbit == nlast) begin
                            s_next.rs = s_reg.lfc[LFC_PEN] ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (s_reg.rt == 4'hf) begin
                        s_next.rpar = s_reg.rpar ^ line_in ^ ~s_reg.lfc[LFC_EPS];
                        s_next.rs = RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (s_reg.rt == 4'hf) begin
                        rword = s_reg.rsh >> (3'h3 - s_reg.lfc[1:0]);
                        s_next.rs = RX_IDLE;
                        s_next.fe = s_next.fe | ~line_in; // see R20
                        s_next.pe = s_next.pe | (s_reg.lfc[LFC_PEN] & s_reg.rpar);
                        s_next.bi = s_next.bi | (rword == 8'h00 && !line_in);
                        if (s_reg.rcnt == lim) begin
                            s_next.oe = 1'b1; // overrun: byte is lost
                        end else begin
                            rx_push = 1'b1;
                            s_next.rxm[s_reg.rwp] = rword;
                            s_next.rwp = s_reg.rwp + PW'(1);
                        end
                    end
                end
                default: s_next.rs = RX_IDLE;
            endcase
        end

        // buffer bookkeeping once both sides are known
        if (tx_pop) begin
            s_next.trp = s_reg.trp + PW'(1);
        end
        if (rx_pop) begin
            s_next.rrp = s_reg.rrp + PW'(1);
        end
        s_next.tcnt = s_reg.tcnt + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
        s_next.rcnt = s_reg.rcnt + (PW+1)'(rx_push) - (PW+1)'(rx_pop);
        // holder going empty is an event; it beats a same-cycle clear
        if (tx_pop && s_reg.tcnt == (PW+1)'(1) && !tx_push) begin
            s_next.thre_pend = 1'b1;
        end
        // buffer resets from control writes act last
        if (req.wr && req.addr == OFS_IID && req.wdata[BUF_RXRST]) begin
            s_next.rwp = '0;                 // see R17
            s_next.rrp = '0;
            s_next.rcnt = '0;
        end
        if (req.wr && req.addr == OFS_IID && req.wdata[BUF_TXRST]) begin
            s_next.twp = '0;
            s_next.trp = '0;
            s_next.tcnt = '0;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
            s_reg.ien <= REG_RST;
            s_reg.lfc <= REG_RST;
            s_reg.mlc <= REG_RST;
            s_reg.div <= DIV_RST;
            s_reg.ts <= TX_IDLE;
            s_reg.rs <= RX_IDLE;
            s_reg.txd <= 1'b1;              // line idles high
            s_reg.rxd_d <= 1'b1;
            s_reg.iid <= IID_NONE;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs
    assign rdata = s_reg.rdata;
    assign txd = s_reg.txd & ~s_reg.lfc[LFC_BRK];
    assign irq = ~s_reg.iid[0];                                 // see R11
    // second channel has no modem pins; its outputs stay inactive
    assign dtr_n = HAS_MODEM ? ~s_reg.mlc[MLC_DTR] : 1'b1;      // see R22
    assign rts_n = HAS_MODEM ? ~s_reg.mlc[MLC_RTS] : 1'b1;      // see R22
    assign tx_buf_full = s_reg.dma_en & (s_reg.tcnt == lim);    // see R19
    assign rx_buf_full = s_reg.dma_en & (s_reg.rcnt >= trig_lvl); // see R19

    // helper: cycles since the last baud tick, and divisor change marker
    logic [15:0] gap;
    logic div_chg;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gap <= 16'h0000;
            div_chg <= 1'b1;
        end else begin
            gap <= s_reg.tick ? 16'h0000 : gap + 16'h0001;
            div_chg <= s_reg.tick ? 1'b0 : (div_chg | (s_next.div != s_reg.div));
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    AST_ZERO_DIV: assert property (s_reg.tick && !div_chg && s_reg.div == 16'h0000
        |-> gap == 16'd31) else $error("zero divisor not treated as 32"); // see R04
    AST_DIV_ONE: assert property (s_reg.div == 16'h0001 ##1 s_reg.div == 16'h0001
        |-> s_reg.tick) else $error("divisor one does not tick each clock"); // see R03
    AST_DAS_WR: assert property (req.wr && req.addr == OFS_DATA && s_reg.lfc[LFC_DAS]
        |=> s_reg.div[7:0] == $past(req.wdata)) else $error("divisor low not written"); // see R10
    AST_MASK: assert property (s_reg.ien[2:0] == 3'h0 [*3] |-> !irq)
        else $error("interrupt raised with all sources disabled"); // see R12
    AST_FREEZE: assert property (req.rd && req.addr == OFS_IID
        |=> rdata[3:0] == $past(s_reg.iid)) else $error("identity not frozen"); // see R15
    AST_START: assert property (s_reg.ts == TX_START && !s_reg.lfc[LFC_BRK] |-> !txd)
        else $error("start bit not low"); // see R06
    AST_LSB: assert property (s_reg.ts == TX_START ##1 s_reg.ts == TX_DATA
        |-> s_reg.txd == $past(s_reg.tsh[0])) else $error("first bit not lsb"); // see R07
    AST_STOP: assert property (s_reg.ts == TX_STOP && !s_reg.lfc[LFC_BRK] |-> txd)
        else $error("stop bit not high"); // see R06
    AST_RX_DR: assert property (rx_push |=> s_reg.rcnt != '0)
        else $error("received byte not flagged"); // see R20

    COV_TX_FRAME: cover property (s_reg.ts == TX_STOP ##1 s_reg.ts == TX_IDLE);
    COV_RX_BYTE: cover property (rx_push);
    COV_IID_READ: cover property (req.rd && req.addr == OFS_IID && irq);
    COV_OVERRUN: cover property ($rose(s_reg.oe));
endmodule : uart_serial_controller
`default_nettype wire

/* remote_terminal.sv */
// partner model: remote serial terminal on the line pair
`timescale 1ns/10ps
`default_nettype none
module remote_terminal #(
    parameter int BIT_CYC = 16 // system clocks per serial bit
) (
    // clock
    input wire logic sys_clk,
    // serial line pair, seen from the terminal
    input wire logic txd,
    output logic rxd
);
    initial rxd = 1'b1; // idle line rests high between frames
    // send one 8n1 frame; start low, lsb first, stop high
    task automatic put_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            rxd <= frame[i];
            repeat (BIT_CYC - 1) @(posedge sys_clk);
        end
    endtask : put_byte
    // catch one frame, sampling each bit at its centre
    task automatic get_byte(output logic [7:0] b);
        int n;
        n = 0;
        // bounded wait so a silent line cannot hang the run
        while (txd !== 1'b0 && n < 4000) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (BIT_CYC / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge sys_clk);
            b[i] = txd;
        end
        repeat (BIT_CYC) @(posedge sys_clk);
        // a missing stop bit spoils the whole frame
        if (txd !== 1'b1) b = 8'hxx;
    endtask : get_byte
endmodule : remote_terminal
`default_nettype wire

/* tb.sv */
// testbench: register access, serial traffic and interrupt checks
`timescale 1ns/10ps
`default_nettype none
module tb;
    import uart_pkg::*;
    logic sys_clk = 1'b0; // 50 MHz system clock
    logic arst_n = 1'b0; // reset, low at start
    reg_req_t req = '0; // register port request
    logic [7:0] rdata; // read answer
    logic rxd, txd, dtr_n, rts_n, irq, tx_buf_full, rx_buf_full;
    logic [7:0] rd_val; // last value read back
    logic [7:0] got; // byte caught by the terminal
    int err_count = 0; // mismatches seen
    int samples_checked = 0; // comparisons made
    always #10 sys_clk = ~sys_clk;
    uart_serial_controller dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .req(req), .rdata(rdata), .rxd(rxd), .txd(txd), .dtr_n(dtr_n),
        .rts_n(rts_n), .irq(irq), .tx_buf_full(tx_buf_full),
        .rx_buf_full(rx_buf_full));
    // divisor one gives sixteen clocks per bit
    remote_terminal #(.BIT_CYC(16)) peer (.sys_clk(sys_clk), .txd(txd),
        .rxd(rxd));
    // one-cycle write strobe
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask : reg_wr
    // one-cycle read strobe, data taken in the following cycle
    task automatic reg_rd(input logic [2:0] a);
        @(posedge sys_clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1 rd_val = rdata;
    endtask : reg_rd
    // compare and count
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    // watchdog: the whole sequence needs about a thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        test_done();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        reg_rd(OFS_IID);
        chk("iid reset", rd_val, 8'h01);
        chk("irq reset", {7'h00, irq}, 8'h00);
        reg_wr(OFS_LFC, 8'h83);
        reg_wr(OFS_DATA, 8'h01);
        reg_wr(OFS_IEN, 8'h00);
        reg_wr(OFS_LFC, 8'h03);
        reg_wr(OFS_IEN, 8'h05);
        reg_rd(OFS_IEN);
        chk("enables", rd_val, 8'h05);
        reg_wr(OFS_LFC, 8'h83);
        reg_rd(OFS_IEN);
        chk("div high", rd_val, 8'h00);
        reg_rd(OFS_DATA);
        chk("div low", rd_val, 8'h01);
        reg_wr(OFS_LFC, 8'h03);
        reg_rd(OFS_LFC);
        chk("format", rd_val, 8'h03);
        // transmit: frame shape and bit order on the line
        reg_wr(OFS_DATA, 8'ha5);
        peer.get_byte(got);
        chk("tx byte", got, 8'ha5);
        // receive with the data interrupt enabled
        peer.put_byte(8'h3c);
        repeat (4) @(posedge sys_clk);
        chk("irq rx", {7'h00, irq}, 8'h01);
        reg_rd(OFS_IID);
        chk("iid rx", rd_val, 8'h04);
        reg_rd(OFS_LCS);
        chk("status", rd_val, 8'h61);
        // the source is cleared in the uart before irq is looked at
        reg_rd(OFS_DATA);
        chk("rx byte", rd_val, 8'h3c);
        repeat (3) @(posedge sys_clk);
        chk("irq clear", {7'h00, irq}, 8'h00);
        // disabled source neither pends nor interrupts
        reg_wr(OFS_IEN, 8'h00);
        peer.put_byte(8'hc3);
        repeat (4) @(posedge sys_clk);
        chk("irq masked", {7'h00, irq}, 8'h00);
        reg_rd(OFS_IID);
        chk("iid masked", rd_val, 8'h01);
        reg_rd(OFS_DATA);
        chk("rx byte 2", rd_val, 8'hc3);
        // modem outputs and an unmapped offset
        reg_wr(OFS_MLC, 8'h03);
        repeat (2) @(posedge sys_clk);
        chk("modem", {6'h00, dtr_n, rts_n}, 8'h00);
        reg_rd(3'h6);
        chk("unmapped", rd_val, 8'h00);
        // buffers on with dma, trigger at one byte
        reg_wr(OFS_IID, 8'h09);
        peer.put_byte(8'h5a);
        repeat (4) @(posedge sys_clk);
        chk("dma flags", {6'h00, tx_buf_full, rx_buf_full}, 8'h01);
        reg_rd(OFS_IID);
        chk("iid buffered", rd_val, 8'hc1);
        reg_rd(OFS_DATA);
        chk("rx byte 3", rd_val, 8'h5a);
        // loopback: eight bits, even parity, two stop bits
        reg_wr(OFS_MLC, 8'h10);
        reg_wr(OFS_LFC, 8'h1f);
        reg_wr(OFS_DATA, 8'h96);
        repeat (240) @(posedge sys_clk);
        reg_rd(OFS_LCS);
        chk("loop status", rd_val, 8'h61);
        reg_rd(OFS_DATA);
        chk("loop byte", rd_val, 8'h96);
        test_done();
    end
endmodule : tb
`default_nettype wire
